/* File: rtl/lcdpd_device.sv */
// display-side command decoder: static drive, table select, partial display
`timescale 1ns/1ps
// How it works
// R1 - static drive forces every pixel, memory untouched
// R2 - all-on beats normal/inverse setting
// R3 - all-on with display off enters power save
// R4 - command 0x70 enters secondary table
// R5 - host enters secondary table before sub commands
// R6 - 0x71 returns to main; no main commands
// R7 - thirteen units, two blocks of start and count
// R8 - duty derived from total active units
// R9 - start 0 count 13 means full 1/104
// R10 - host sets block two 0/0 for one block
// R11 - low nibble unit, upper nibble selects parameter
// R12 - upper nibble 4 applies blocks, changes duty
// R13 - host keeps fixed partial command order
// R14 - host keeps blocks from overlapping
// R15 - host keeps first start at 12 or below
// R16 - host keeps total units at 13 or below
// R17 - blocks shown adjacent; data contiguous in memory
// R18 - partial execute changes only the blocks and duty
// R19 - host blanks display and retunes voltages around; the partial sequence of lcdpd_host sends neither
// R20 - n-line inverse set only in secondary table
// R21 - contrast register written only in secondary table
// R22 - host loads contrast all ones when unused
// R23 - reset restores full display and contrast ones
// R24 - one-bit table select, reset to main
module lcdpd_device
	import lcdpd_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       rst_n_in,
	input  wire logic       ce_in,
	lcdpd_if.device         link,
	input  wire logic       pixel_mem_in,       // display_memory bit being scanned
	output logic            pixel_out,          // bit sent to the segment driver
	output logic            all_on_out,
	output logic            inverse_out,
	output logic            display_on_out,
	output logic            power_save_out,
	output logic            sub_table_out,
	output logic [3:0]      blk1_start_out,
	output logic [3:0]      blk1_count_out,
	output logic [3:0]      blk2_start_out,
	output logic [3:0]      blk2_count_out,
	output logic [3:0]      active_units_out,
	output logic [6:0]      duty_lines_out,
	output logic [3:0]      nline_out,
	output logic [7:0]      contrast_voltage_register_out
);
	typedef struct packed {
		// table select and main-table mode bits
		lcdpd_tbl_t tbl;
		logic       all_on;
		logic       inverse;
		logic       disp_on;
		logic       power_save;
		logic       pixel;
		// block parameters: staged by commands, applied on execute
		logic [3:0] p1_start;   // staged parameters
		logic [3:0] p1_count;
		logic [3:0] p2_start;
		logic [3:0] p2_count;
		logic [3:0] a1_start;   // applied blocks
		logic [3:0] a1_count;
		logic [3:0] a2_start;
		logic [3:0] a2_count;
		logic [3:0] units;
		logic [6:0] duty;
		// secondary-table settings
		logic [3:0] nline;
		logic [7:0] con_stage;
		logic [7:0] contrast;
	} lcdpd_dev_t;
	lcdpd_dev_t st;
	lcdpd_dev_t next_st;

	// ****************************************
	// helpers
	// ****************************************
	// common lines driven for a number of active units
	function automatic logic [6:0] units_to_lines(input logic [3:0] u);
		logic [6:0] l;
		l = 7'(u) * 7'(LCDPD_LINES_PER_UNIT);
		return l;
	endfunction

	// first block covering the whole panel
	function automatic logic is_full(input logic [3:0] s, input logic [3:0] c);
		return (s == 4'h0) && (c == LCDPD_UNITS_FULL);
	endfunction

	// ****************************************
	// command decode and pixel path
	// ****************************************
	always_comb begin
		logic       cmd;
		logic [3:0] hi;
		logic [3:0] lo;
		logic [3:0] tot;
		next_st = st;
		// only command bytes (select low) are decoded
		cmd = link.cmd_valid && !link.command_data_select;
		hi  = link.cmd_byte[7:4];
		lo  = link.cmd_byte[3:0];
		// total of the staged counts, legal sums fit four bits
		tot = st.p1_count + st.p2_count;
		if (cmd) begin
			case (st.tbl) // see R24
				LCDPD_TBL_MAIN: begin
					// main table: table entry and the three mode bits
					if (link.cmd_byte == LCDPD_CMD_SUB_ENTER)
						next_st.tbl = LCDPD_TBL_SUB; // see R4
					else if (link.cmd_byte[7:1] == LCDPD_CMD_STATIC)
						next_st.all_on = link.cmd_byte[0]; // see R1
					else if (link.cmd_byte[7:1] == LCDPD_CMD_DISP)
						next_st.disp_on = link.cmd_byte[0];
					else if (link.cmd_byte[7:1] == LCDPD_CMD_INVERSE)
						next_st.inverse = link.cmd_byte[0];
				end
				LCDPD_TBL_SUB: begin
					// main-table bytes are dropped here, see R6
					if (link.cmd_byte == LCDPD_CMD_SUB_EXIT)
						next_st.tbl = LCDPD_TBL_MAIN; // see R6
					else if (link.cmd_byte == LCDPD_CMD_CON_GO)
						next_st.contrast = st.con_stage; // see R21
					else begin
						case (hi) // see R11
							LCDPD_NIB_B1_START: next_st.p1_start = lo;
							LCDPD_NIB_B1_COUNT: next_st.p1_count = lo;
							LCDPD_NIB_B2_START: next_st.p2_start = lo;
							LCDPD_NIB_B2_COUNT: next_st.p2_count = lo;
							LCDPD_NIB_PARTIAL_GO: begin
								// only blocks and duty move, see R18
								next_st.a1_start = st.p1_start; // see R7 R12
								next_st.a1_count = st.p1_count;
								// whole panel: second block dropped, full duty
								if (is_full(st.p1_start, st.p1_count)) begin
									next_st.a2_start = 4'h0; // see R9
									next_st.a2_count = 4'h0;
									next_st.units    = LCDPD_UNITS_FULL;
									next_st.duty     = LCDPD_LINES_FULL;
								end else begin
									next_st.a2_start = st.p2_start;
									next_st.a2_count = st.p2_count;
									next_st.units    = tot; // see R8 R17
									next_st.duty     = units_to_lines(tot);
								end
							end
							LCDPD_NIB_NLINE:  next_st.nline = lo; // see R20
							// contrast nibbles are staged and only land on execute
							LCDPD_NIB_CON_HI: next_st.con_stage[7:4] = lo; // see R21
							LCDPD_NIB_CON_LO: next_st.con_stage[3:0] = lo;
							default:          next_st.nline = st.nline;
						endcase
					end
				end
				default: next_st.tbl = LCDPD_TBL_MAIN;
			endcase
		end
		// power save follows the mode bits one cycle later
		next_st.power_save = st.all_on && !st.disp_on; // see R3
		// all-on overrides inversion and leaves memory alone, see R1 R2
		next_st.pixel = st.all_on ? 1'b1 : (pixel_mem_in ^ st.inverse);
	end

	// ****************************************
	// state register
	// ****************************************
	// reset brings back the whole panel at full duty, contrast all ones
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st           <= '0;
			st.tbl       <= LCDPD_TBL_MAIN; // see R24
			st.p1_count  <= LCDPD_UNITS_FULL; // see R23
			st.a1_count  <= LCDPD_UNITS_FULL;
			st.units     <= LCDPD_UNITS_FULL;
			st.duty      <= LCDPD_LINES_FULL;
			st.nline     <= LCDPD_NLINE_RST;
			st.con_stage <= LCDPD_CONTRAST_RST;
			st.contrast  <= LCDPD_CONTRAST_RST; // see R23
		end else if (ce_in) begin
			// low enable freezes every field
			st <= next_st;
		end
	end

	// ****************************************
	// outputs straight from the state register
	// ****************************************
	// pixel and mode bits
	assign pixel_out                     = st.pixel;
	assign all_on_out                    = st.all_on;
	assign inverse_out                   = st.inverse;
	assign display_on_out                = st.disp_on;
	assign power_save_out                = st.power_save;
	assign sub_table_out                 = (st.tbl == LCDPD_TBL_SUB);

	// applied blocks and duty
	assign blk1_start_out                = st.a1_start;
	assign blk1_count_out                = st.a1_count;
	assign blk2_start_out                = st.a2_start;
	assign blk2_count_out                = st.a2_count;
	assign active_units_out              = st.units;
	assign duty_lines_out                = st.duty;

	// secondary-table registers
	assign nline_out                     = st.nline;
	assign contrast_voltage_register_out = st.contrast;
endmodule // lcdpd_device

/* File: rtl/lcdpd_host.sv */
// host controller: turns register orders into command byte sequences
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module lcdpd_host
	import lcdpd_pkg::*;
(
	input  wire logic       clock_in,
	input  wire logic       rst_n_in,
	input  wire logic       ce_in,
	input  wire logic [2:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic [7:0]      rdata_out,
	lcdpd_if.host           link
);
	typedef enum logic [1:0] {LCDPD_OP_RAW, LCDPD_OP_PART, LCDPD_OP_CON, LCDPD_OP_NLINE} lcdpd_op_t;
	typedef struct packed {
		logic [7:0] raw;
		logic [7:0] block1;   // count high nibble, start low nibble
		logic [7:0] block2;
		logic [7:0] contrast;
		logic [3:0] nline;
		lcdpd_op_t  op;
		logic [2:0] step;
		logic       busy;
		logic       err;
		logic       valid;
		logic [7:0] byte_q;
		logic [7:0] rdata;
	} lcdpd_host_t;
	lcdpd_host_t st;
	lcdpd_host_t next_st;

	// ****************************************
	// byte for each step of a sequence
	// ****************************************
	function automatic logic [7:0] seq_byte(input lcdpd_host_t s, output logic last);
		logic [7:0] b;
		b    = LCDPD_CMD_SUB_ENTER;
		last = 1'b0;
		case (s.op)
			LCDPD_OP_RAW: begin
				b    = s.raw;
				last = 1'b1;
			end
			LCDPD_OP_PART: begin
				case (s.step) // fixed order, see R13
					3'h1: b = {LCDPD_NIB_B1_START, s.block1[3:0]};
					3'h2: b = {LCDPD_NIB_B1_COUNT, s.block1[7:4]};
					3'h3: b = {LCDPD_NIB_B2_START, s.block2[3:0]};
					3'h4: b = {LCDPD_NIB_B2_COUNT, s.block2[7:4]};
					3'h5: b = {LCDPD_NIB_PARTIAL_GO, 4'h0};
					3'h6: begin
						b    = LCDPD_CMD_SUB_EXIT; // see R6
						last = 1'b1;
					end
					default: b = LCDPD_CMD_SUB_ENTER; // see R5
				endcase
			end
			LCDPD_OP_CON: begin
				case (s.step)
					3'h1: b = {LCDPD_NIB_CON_HI, s.contrast[7:4]};
					3'h2: b = {LCDPD_NIB_CON_LO, s.contrast[3:0]};
					3'h3: b = LCDPD_CMD_CON_GO;
					3'h4: begin
						b    = LCDPD_CMD_SUB_EXIT;
						last = 1'b1;
					end
					default: b = LCDPD_CMD_SUB_ENTER;
				endcase
			end
			default: begin
				case (s.step)
					3'h1: b = {LCDPD_NIB_NLINE, s.nline};
					3'h2: begin
						b    = LCDPD_CMD_SUB_EXIT;
						last = 1'b1;
					end
					default: b = LCDPD_CMD_SUB_ENTER;
				endcase
			end
		endcase
		return b;
	endfunction

	// ****************************************
	// block parameter legality
	// ****************************************
	function automatic logic blocks_bad(input logic [7:0] b1, input logic [7:0] b2);
		logic [4:0] sum;
		logic       full;
		logic       ovl;
		full = (b1[3:0] == 4'h0) && (b1[7:4] == LCDPD_UNITS_FULL);
		sum  = {1'b0, b1[7:4]} + {1'b0, b2[7:4]};
		ovl  = (b1[7:4] != 4'h0) && (b2[7:4] != 4'h0) &&
		       ({1'b0, b1[3:0]} < {1'b0, b2[3:0]} + {1'b0, b2[7:4]}) &&
		       ({1'b0, b2[3:0]} < {1'b0, b1[3:0]} + {1'b0, b1[7:4]});
		if (full)
			return 1'b0;
		return (b1[3:0] > LCDPD_START_MAX) || (sum > {1'b0, LCDPD_UNITS_FULL}) || ovl ||
		       ((b2[7:4] == 4'h0) && (b2[3:0] != 4'h0)); // see R14 R15 R16 R10
	endfunction

	// ****************************************
	// next state: register writes, reads, sequencer
	// ****************************************
	always_comb begin
		logic       last;
		logic [7:0] b;
		last    = 1'b0;
		next_st = st;
		next_st.valid = 1'b0;
		next_st.rdata = 8'h00;
		b = seq_byte(st, last);
		if (st.busy) begin
			next_st.valid  = 1'b1;
			next_st.byte_q = b;
			next_st.step   = st.step + 3'h1;
			if (last)
				next_st.busy = 1'b0;
		end
		if (rd_in) begin
			case (addr_in)
				LCDPD_REG_RAW:      next_st.rdata = st.raw;
				LCDPD_REG_BLOCK1:   next_st.rdata = st.block1;
				LCDPD_REG_BLOCK2:   next_st.rdata = st.block2;
				LCDPD_REG_CONTRAST: next_st.rdata = st.contrast;
				LCDPD_REG_NLINE:    next_st.rdata = {4'h0, st.nline};
				LCDPD_REG_STATUS:   next_st.rdata = {6'h00, st.err, st.busy};
				default:            next_st.rdata = 8'h00;
			endcase
		end
		// orders are ignored while a sequence runs
		if (wr_in && !st.busy) begin
			next_st.step = 3'h0;
			case (addr_in)
				LCDPD_REG_RAW: begin
					next_st.raw  = wdata_in;
					next_st.op   = LCDPD_OP_RAW;
					next_st.busy = 1'b1;
				end
				LCDPD_REG_BLOCK1:   next_st.block1   = wdata_in;
				LCDPD_REG_BLOCK2:   next_st.block2   = wdata_in;
				LCDPD_REG_CONTRAST: next_st.contrast = wdata_in;
				LCDPD_REG_NLINE:    next_st.nline    = wdata_in[3:0];
				LCDPD_REG_CTRL: begin
					next_st.err = 1'b0;
					if (wdata_in[LCDPD_CTRL_PARTIAL]) begin
						next_st.op   = LCDPD_OP_PART;
						next_st.err  = blocks_bad(st.block1, st.block2);
						next_st.busy = !blocks_bad(st.block1, st.block2);
					end else if (wdata_in[LCDPD_CTRL_CON]) begin
						next_st.op   = LCDPD_OP_CON;
						next_st.busy = 1'b1;
					end else if (wdata_in[LCDPD_CTRL_NLINE]) begin
						next_st.op   = LCDPD_OP_NLINE;
						next_st.busy = 1'b1;
					end
				end
				default: next_st.err = st.err;
			endcase
		end
	end

	// state register
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st          <= '0;
			st.block1   <= {LCDPD_UNITS_FULL, 4'h0};
			st.contrast <= LCDPD_CONTRAST_RST; // see R22
		end else if (ce_in) begin
			st <= next_st;
		end
	end

	// outputs straight from the state register, command_data_select tied low
	assign rdata_out                = st.rdata;
	assign link.cmd_valid           = st.valid;
	assign link.cmd_byte            = st.byte_q;
	assign link.command_data_select = 1'b0;
endmodule // lcdpd_host

/* File: rtl/lcdpd_if.sv */
// command link between host controller and display decoder
`timescale 1ns/1ps
interface lcdpd_if;
	logic       cmd_valid;           // one-cycle strobe per byte
	logic       command_data_select; // low marks a command byte
	logic [7:0] cmd_byte;
	modport device (input cmd_valid, input command_data_select, input cmd_byte);
	modport host (output cmd_valid, output command_data_select, output cmd_byte);
endinterface : lcdpd_if

/* File: rtl/lcdpd_pkg.sv */
// shared constants for the partial display command decoder and its host
package lcdpd_pkg;
	// ****************************************
	// geometry
	// ****************************************
	localparam int        LCDPD_UNITS          = 13;  // display units on the panel
	localparam int        LCDPD_LINES_PER_UNIT = 8;   // common lines in one unit
	localparam logic [3:0] LCDPD_UNITS_FULL    = 4'hd;
	localparam logic [3:0] LCDPD_START_MAX     = 4'hc;
	localparam logic [6:0] LCDPD_LINES_FULL    = 7'h68; // 1/104 duty
	// ****************************************
	// command bytes
	// ****************************************
	localparam logic [7:0] LCDPD_CMD_SUB_ENTER  = 8'h70;
	localparam logic [7:0] LCDPD_CMD_SUB_EXIT   = 8'h71;
	localparam logic [6:0] LCDPD_CMD_STATIC     = 7'h52; // 1010_010x
	localparam logic [6:0] LCDPD_CMD_DISP       = 7'h57; // 1010_111x
	localparam logic [6:0] LCDPD_CMD_INVERSE    = 7'h53; // 1010_011x
	localparam logic [3:0] LCDPD_NIB_B1_START   = 4'h0;
	localparam logic [3:0] LCDPD_NIB_B1_COUNT   = 4'h1;
	localparam logic [3:0] LCDPD_NIB_B2_START   = 4'h2;
	localparam logic [3:0] LCDPD_NIB_B2_COUNT   = 4'h3;
	localparam logic [3:0] LCDPD_NIB_PARTIAL_GO = 4'h4;
	localparam logic [3:0] LCDPD_NIB_NLINE      = 4'h5;
	localparam logic [3:0] LCDPD_NIB_CON_HI     = 4'h8;
	localparam logic [3:0] LCDPD_NIB_CON_LO     = 4'h9;
	localparam logic [7:0] LCDPD_CMD_CON_GO     = 8'ha0;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] LCDPD_CONTRAST_RST   = 8'hff;
	localparam logic [3:0] LCDPD_NLINE_RST      = 4'h0;
	// ****************************************
	// host register offsets and fields
	// ****************************************
	localparam logic [2:0] LCDPD_REG_RAW      = 3'h0;
	localparam logic [2:0] LCDPD_REG_BLOCK1   = 3'h1;
	localparam logic [2:0] LCDPD_REG_BLOCK2   = 3'h2;
	localparam logic [2:0] LCDPD_REG_CONTRAST = 3'h3;
	localparam logic [2:0] LCDPD_REG_NLINE    = 3'h4;
	localparam logic [2:0] LCDPD_REG_CTRL     = 3'h5;
	localparam logic [2:0] LCDPD_REG_STATUS   = 3'h6;
	localparam int         LCDPD_CTRL_PARTIAL = 0;
	localparam int         LCDPD_CTRL_CON     = 1;
	localparam int         LCDPD_CTRL_NLINE   = 2;
	typedef enum logic {LCDPD_TBL_MAIN, LCDPD_TBL_SUB} lcdpd_tbl_t;
endpackage : lcdpd_pkg

/* File: testbench/lcd_sub_table_partial_display_ctrl_bench.sv */
// self-checking bench: host controller driving the display decoder
`timescale 1ns/1ps
module lcd_sub_table_partial_display_ctrl_bench;
	import lcdpd_pkg::*;
	logic       clock_in = 1'b0;
	logic       rst_n_in = 1'b0;
	logic       ce_in    = 1'b1;
	logic [2:0] addr_in  = 3'h0;
	logic [7:0] wdata_in = 8'h00;
	logic       wr_in    = 1'b0;
	logic       rd_in    = 1'b0;
	logic       pixel_mem_in = 1'b0;
	logic [7:0] rdata_out, contrast_voltage_register_out;
	logic       pixel_out, all_on_out, inverse_out, display_on_out, power_save_out, sub_table_out;
	logic [3:0] blk1_start_out, blk1_count_out, blk2_start_out, blk2_count_out;
	logic [3:0] active_units_out, nline_out;
	logic [6:0] duty_lines_out;
	int         error_cnt = 0;
	int         compares  = 0;
	lcdpd_if link ();
	lcdpd_host u_lcdpd_host (.clock_in, .rst_n_in, .ce_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out, .link(link.host));
	lcdpd_device u_lcdpd_device (.clock_in, .rst_n_in, .ce_in, .link(link.device), .pixel_mem_in,
		.pixel_out, .all_on_out, .inverse_out, .display_on_out, .power_save_out, .sub_table_out,
		.blk1_start_out, .blk1_count_out, .blk2_start_out, .blk2_count_out, .active_units_out,
		.duty_lines_out, .nline_out, .contrast_voltage_register_out);
	lcdpd_monitor u_lcdpd_monitor (.clock_in, .rst_n_in, .ce_in, .cmd_valid(link.cmd_valid),
		.command_data_select(link.command_data_select), .cmd_byte(link.cmd_byte), .pixel_mem_in,
		.pixel_out, .all_on_out, .inverse_out, .display_on_out, .power_save_out, .sub_table_out,
		.blk1_start_out, .blk1_count_out, .blk2_start_out, .blk2_count_out, .active_units_out,
		.duty_lines_out, .nline_out, .contrast_voltage_register_out);
	// clock at 20 MHz
	always #25 clock_in = ~clock_in;
	// ****
	// tasks
	// ****
	task automatic wrap_up;
		$display("compares=%0d error_cnt=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask
	// register read compared with an expected byte
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] v;
		rd(a, v);
		chk(v, exp);
	endtask
	// poll busy with a bound, then let the decoder outputs land
	task automatic settle;
		logic [7:0] s;
		for (int i = 0; i < 40; i++) begin
			rd(LCDPD_REG_STATUS, s);
			if (s[0] === 1'b0) begin
				repeat (2) @(posedge clock_in);
				#1;
				return;
			end
		end
		error_cnt++;
		wrap_up();
	endtask
	task automatic raw(input logic [7:0] b);
		wr(LCDPD_REG_RAW, b);
		settle();
	endtask
	task automatic part(input logic [7:0] b1, input logic [7:0] b2);
		wr(LCDPD_REG_BLOCK1, b1);
		wr(LCDPD_REG_BLOCK2, b2);
		wr(LCDPD_REG_CTRL, 8'h01);
		settle();
	endtask
	task automatic chk_reset;
		chk(blk1_count_out, 8'h0d);
		chk(active_units_out, 8'h0d);
		chk(duty_lines_out, LCDPD_LINES_FULL);
		chk(contrast_voltage_register_out, 8'hff);
		chk(sub_table_out, 8'h00);
		chk(nline_out, 8'h00);
		rd_chk(LCDPD_REG_BLOCK1, 8'hd0);
		rd_chk(3'h7, 8'h00);
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		repeat (5) @(posedge clock_in);
		rst_n_in <= 1'b1;
		chk_reset();
		raw(8'ha5);
		chk(all_on_out, 8'h01);
		chk(pixel_out, 8'h01);
		chk(power_save_out, 8'h01);
		raw(8'haf);
		chk(power_save_out, 8'h00);
		chk(display_on_out, 8'h01);
		raw(8'ha7);
		chk(pixel_out, 8'h01);
		chk(inverse_out, 8'h01);
		raw(8'ha4);
		chk(pixel_out, 8'h01);
		@(posedge clock_in);
		pixel_mem_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		#1 chk(pixel_out, 8'h00);
		// low clock enable freezes the pixel path
		@(posedge clock_in);
		ce_in        <= 1'b0;
		pixel_mem_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		#1 chk(pixel_out, 8'h00);
		@(posedge clock_in);
		ce_in <= 1'b1;
		raw(8'h56);
		chk(nline_out, 8'h00);
		raw(8'h70);
		chk(sub_table_out, 8'h01);
		raw(8'ha5);
		chk(all_on_out, 8'h00);
		raw(8'h56);
		raw(8'h71);
		chk(sub_table_out, 8'h00);
		chk(nline_out, 8'h06);
		wr(LCDPD_REG_CONTRAST, 8'h5a);
		wr(LCDPD_REG_NLINE, 8'h03);
		raw(8'hae);
		chk(display_on_out, 8'h00);
		part(8'h20, 8'h54);
		chk({blk1_count_out, blk1_start_out}, 8'h20);
		chk({blk2_count_out, blk2_start_out}, 8'h54);
		chk(duty_lines_out, 8'h38);
		chk({nline_out, contrast_voltage_register_out[3:0]}, 8'h6f);
		wr(LCDPD_REG_CTRL, 8'h02);
		settle();
		chk(contrast_voltage_register_out, 8'h5a);
		wr(LCDPD_REG_CTRL, 8'h04);
		settle();
		chk(nline_out, 8'h03);
		part(8'hd0, 8'h34);
		chk({blk2_count_out, blk2_start_out}, 8'h00);
		chk(duty_lines_out, LCDPD_LINES_FULL);
		part(8'h1c, 8'h00);
		chk(duty_lines_out, 8'h08);
		part(8'h1d, 8'h00);
		rd_chk(LCDPD_REG_STATUS, 8'h02);
		part(8'h70, 8'h77);
		rd_chk(LCDPD_REG_STATUS, 8'h02);
		part(8'h30, 8'h22);
		rd_chk(LCDPD_REG_STATUS, 8'h02);
		chk(active_units_out, 8'h01);
		@(posedge clock_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		rst_n_in <= 1'b1;
		chk_reset();
		wrap_up();
	end
endmodule // lcd_sub_table_partial_display_ctrl_bench

/* File: testbench/lcdpd_monitor.sv */
// concurrent checks on the command link and the decoder outputs
`timescale 1ns/1ps
module lcdpd_monitor
	import lcdpd_pkg::*;
(
	input wire logic       clock_in,
	input wire logic       rst_n_in,
	input wire logic       ce_in,
	input wire logic       cmd_valid,
	input wire logic       command_data_select,
	input wire logic [7:0] cmd_byte,
	input wire logic       pixel_mem_in,
	input wire logic       pixel_out,
	input wire logic       all_on_out,
	input wire logic       inverse_out,
	input wire logic       display_on_out,
	input wire logic       power_save_out,
	input wire logic       sub_table_out,
	input wire logic [3:0] blk1_start_out,
	input wire logic [3:0] blk1_count_out,
	input wire logic [3:0] blk2_start_out,
	input wire logic [3:0] blk2_count_out,
	input wire logic [3:0] active_units_out,
	input wire logic [6:0] duty_lines_out,
	input wire logic [3:0] nline_out,
	input wire logic [7:0] contrast_voltage_register_out
);
	// ****
	// command sequences
	// ****
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_cmd(logic [7:0] b);
		ce_in && cmd_valid && !command_data_select && cmd_byte == b;
	endsequence
	sequence s_sub_nib(logic [3:0] n);
		ce_in && cmd_valid && !command_data_select && sub_table_out && cmd_byte[7:4] == n;
	endsequence
	// ****
	// properties
	// ****
	a_pixel_forced: assert property (
		ce_in && rst_n_in |=> pixel_out == $past(all_on_out || (pixel_mem_in ^ inverse_out)))
		else $error("pixel output wrong");
	a_power_save: assert property (
		ce_in && rst_n_in |=> power_save_out == $past(all_on_out && !display_on_out))
		else $error("power save wrong");
	a_sub_enter: assert property (s_cmd(8'h70) |=> sub_table_out)
		else $error("secondary table not entered");
	a_sub_exit: assert property (s_cmd(8'h71) |=> !sub_table_out)
		else $error("secondary table not left");
	a_main_ignored: assert property (
		ce_in && cmd_valid && !command_data_select && sub_table_out
		&& cmd_byte[7:4] == 4'ha && cmd_byte != 8'ha0 |=> $stable(all_on_out)
		&& $stable(inverse_out) && $stable(display_on_out))
		else $error("main byte acted in secondary table");
	a_regs_main_hold: assert property (
		!sub_table_out |=> $stable(contrast_voltage_register_out) && $stable(nline_out))
		else $error("register changed in main table");
	a_exec_duty_only: assert property (
		s_sub_nib(4'h4) |=> $stable(contrast_voltage_register_out)
		&& $stable(nline_out) && $stable(inverse_out))
		else $error("partial execute touched other settings");
	a_units_sum: assert property (active_units_out == blk1_count_out + blk2_count_out)
		else $error("active units not the block sum");
	a_duty_units: assert property (duty_lines_out == {active_units_out, 3'b000})
		else $error("duty lines not eight per unit");
	a_full_blk2: assert property (
		blk1_start_out == 4'h0 && blk1_count_out == 4'hd
		|-> blk2_start_out == 4'h0 && blk2_count_out == 4'h0)
		else $error("second block kept in full display");
endmodule // lcdpd_monitor
